// File: design/tick_pkg.sv
package tick_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] RATE_CTRL_IDX = 8'h0b;
	localparam logic [7:0] SRC_CFG_IDX = 8'h10;
	localparam logic [7:0] EVT_STATUS_IDX = 8'h11;
	localparam logic [7:0] EVT_MASK_IDX = 8'h12;
	localparam logic [7:0] COUNT_VIEW_IDX = 8'h13;
	localparam int ADDR_W = 12;

	// Fields of tick_rate_control.
	localparam int DEC_SEL_BIT = 7;
	localparam int PRESCALE_LSB = 4;
	localparam int PRESCALE_W = 3;
	localparam int MODULUS_LSB = 0;
	localparam int MODULUS_W = 4;
	localparam logic [7:0] RATE_CTRL_RESET = 8'h00;

	// Fields of the source configuration register.
	localparam int SRC_SEL_BIT = 0;
	localparam int PSTOP_EN_BIT = 1;
	localparam int PSTOP_SEL_BIT = 2;
	localparam logic [2:0] SRC_CFG_RESET = 3'h0;

	// Event status and mask layout.
	localparam int TICK_EVT_BIT = 0;

	// Prescale lengths in source cycles.
	localparam int PRESCALE_CNT_W = 18;
	localparam int BIN_BASE_LOG2 = 10;
	localparam logic [PRESCALE_CNT_W-1:0] DEC_LEN_0 = 18'd1000;
	localparam logic [PRESCALE_CNT_W-1:0] DEC_LEN_1 = 18'd2000;
	localparam logic [PRESCALE_CNT_W-1:0] DEC_LEN_2 = 18'd5000;
	localparam logic [PRESCALE_CNT_W-1:0] DEC_LEN_3 = 18'd10000;
	localparam logic [PRESCALE_CNT_W-1:0] DEC_LEN_4 = 18'd20000;
	localparam logic [PRESCALE_CNT_W-1:0] DEC_LEN_5 = 18'd50000;
	localparam logic [PRESCALE_CNT_W-1:0] DEC_LEN_6 = 18'd100000;
	localparam logic [PRESCALE_CNT_W-1:0] DEC_LEN_7 = 18'd200000;

	// APB request as seen by the slave.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// Whole state of the timer block.
	typedef struct packed {
		logic [7:0] rate_ctrl;
		logic src_sel;
		logic pstop_en;
		logic pstop_sel;
		logic evt_flag;
		logic evt_mask;
		logic [PRESCALE_CNT_W-1:0] pre_cnt;
		logic [MODULUS_W-1:0] mod_cnt;
		logic irc_prev;
		logic osc_prev;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
		logic tick;
	} tick_state_t;

endpackage

// File: design/tick_period_decode.sv
`timescale 1ns/1ps
// Turns the rate control byte into a prescale length and an off flag.
module tick_period_decode (
	input wire logic [7:0] rate_ctrl_i,
	output logic timer_off_o,
	output logic [tick_pkg::PRESCALE_CNT_W-1:0] prescale_len_o
);

	logic [tick_pkg::PRESCALE_W-1:0] code;

	// Binary family is a power of two; decimal family is a lookup.
	always_comb begin
		code = rate_ctrl_i[tick_pkg::PRESCALE_LSB +: tick_pkg::PRESCALE_W];
		timer_off_o = 1'b0;
		prescale_len_o = '0;
		if (rate_ctrl_i[tick_pkg::DEC_SEL_BIT]) begin // R5
			unique case (code) // R9
				3'h0: prescale_len_o = tick_pkg::DEC_LEN_0;
				3'h1: prescale_len_o = tick_pkg::DEC_LEN_1;
				3'h2: prescale_len_o = tick_pkg::DEC_LEN_2;
				3'h3: prescale_len_o = tick_pkg::DEC_LEN_3;
				3'h4: prescale_len_o = tick_pkg::DEC_LEN_4;
				3'h5: prescale_len_o = tick_pkg::DEC_LEN_5;
				3'h6: prescale_len_o = tick_pkg::DEC_LEN_6;
				3'h7: prescale_len_o = tick_pkg::DEC_LEN_7;
			endcase
		end else if (code == 3'h0) begin
			timer_off_o = 1'b1; // R6
		end else begin
			// Code 1 gives 2^10 and each step doubles the length.
			prescale_len_o = tick_pkg::PRESCALE_CNT_W'(1) <<
				(tick_pkg::BIN_BASE_LOG2 - 1 + int'(code)); // R6
		end
	end

endmodule

// File: design/periodic_tick_timer.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// R1: Source select 0 counts internal RC clock edges, 1 counts oscillator edges.
// R2: In stop mode count only in pseudo-stop with oscillator source, else freeze.
// R3: Any write to the rate control register restarts the period from zero.
// R4: A change of source select, including forced clear, restarts the period.
// R5: Bit 7 picks binary (0) or decimal (1) prescaler family.
// R6: Binary codes 1..7 give 2^10..2^16 cycles; code 0 turns timer off.
// R7: Modulus field n multiplies the prescale period by n+1.
// R8: Control resets to zero, timer off; software writes zero to disable.
// R9: Decimal codes give 1,2,5,10,20,50,100,200 thousand cycles times modulus.
// R10: Oscillator source only settable with oscillator good; loss clears it.
// R11: Pseudo-stop running needs the pseudo-stop enable bit set.
// R12: Frozen counts are kept and counting resumes from them.
// R13: Each period end sets the tick event flag and starts the next period; a period end in the same cycle as a restart sets no flag and no tick.
module periodic_tick_timer (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire tick_pkg::apb_req_t apb_i,
	output logic pready_o,
	output logic pslverr_o,
	output logic [31:0] prdata_o,
	input wire logic internal_rc_clock_i,
	input wire logic external_osc_clock_i,
	input wire logic oscillator_good_status_i,
	input wire logic stop_mode_i,
	output logic irq_o,
	output logic tick_o
);

	tick_pkg::tick_state_t state_reg;
	tick_pkg::tick_state_t state_next;
	logic timer_off;
	logic [tick_pkg::PRESCALE_CNT_W-1:0] prescale_len;

	// Period length decode of the current control byte.
	tick_period_decode u_decode (
		.rate_ctrl_i(state_reg.rate_ctrl),
		.timer_off_o(timer_off),
		.prescale_len_o(prescale_len)
	);

	logic [7:0] reg_idx;
	logic addr_ok;
	logic access;
	logic wr_done;
	logic rd_done;
	logic src_edge;
	logic run_ok;
	logic restart;
	logic period_end;
	logic new_src;
	logic [31:0] rd_value;

	// Bus decode; the access completes on the edge where pready is seen high.
	always_comb begin
		reg_idx = 8'(apb_i.paddr[tick_pkg::ADDR_W-1:2]);
		addr_ok = (apb_i.paddr[1:0] == 2'h0) &&
			(reg_idx == tick_pkg::RATE_CTRL_IDX || reg_idx == tick_pkg::SRC_CFG_IDX ||
			reg_idx == tick_pkg::EVT_STATUS_IDX || reg_idx == tick_pkg::EVT_MASK_IDX ||
			reg_idx == tick_pkg::COUNT_VIEW_IDX);
		access = apb_i.psel && apb_i.penable;
		wr_done = access && state_reg.pready && apb_i.pwrite && addr_ok;
		rd_done = access && state_reg.pready && !apb_i.pwrite && addr_ok;
	end

	// Read mux, captured on the same edge that raises pready.
	always_comb begin
		rd_value = 32'h0;
		unique case (reg_idx)
			tick_pkg::RATE_CTRL_IDX: rd_value = {24'h0, state_reg.rate_ctrl};
			tick_pkg::SRC_CFG_IDX: rd_value = {29'h0, state_reg.pstop_sel,
				state_reg.pstop_en, state_reg.src_sel};
			tick_pkg::EVT_STATUS_IDX: rd_value = {31'h0, state_reg.evt_flag};
			tick_pkg::EVT_MASK_IDX: rd_value = {31'h0, state_reg.evt_mask};
			tick_pkg::COUNT_VIEW_IDX: rd_value = {10'h0, state_reg.mod_cnt,
				state_reg.pre_cnt};
			default: rd_value = 32'h0;
		endcase
	end

	// Counting conditions.
	always_comb begin
		// Both source clocks are synchronous inputs, so a plain edge detect is safe.
		src_edge = state_reg.src_sel ? (external_osc_clock_i && !state_reg.osc_prev) // R1
			: (internal_rc_clock_i && !state_reg.irc_prev); // R1
		// Stop freezes the count unless pseudo-stop keeps the oscillator path alive.
		run_ok = !stop_mode_i ||
			(state_reg.pstop_sel && state_reg.src_sel && state_reg.pstop_en); // R2 R11
		// Source select: set needs oscillator good, loss forces it clear.
		new_src = state_reg.src_sel;
		if (wr_done && reg_idx == tick_pkg::SRC_CFG_IDX) begin
			new_src = apb_i.pwdata[tick_pkg::SRC_SEL_BIT] && oscillator_good_status_i; // R10
		end
		if (!oscillator_good_status_i) begin
			new_src = 1'b0; // R10
		end
		restart = (wr_done && reg_idx == tick_pkg::RATE_CTRL_IDX) || // R3
			(new_src != state_reg.src_sel); // R4
		period_end = !timer_off && run_ok && src_edge &&
			(state_reg.pre_cnt == prescale_len - tick_pkg::PRESCALE_CNT_W'(1)) &&
			(state_reg.mod_cnt == state_reg.rate_ctrl[tick_pkg::MODULUS_LSB +:
			tick_pkg::MODULUS_W]); // R7
	end

	// Next state of the whole block.
	always_comb begin
		state_next = state_reg;
		state_next.irc_prev = internal_rc_clock_i;
		state_next.osc_prev = external_osc_clock_i;
		state_next.src_sel = new_src;
		state_next.tick = 1'b0;

		// APB slave: one wait state on every access.
		state_next.pready = access && !state_reg.pready;
		state_next.pslverr = access && !state_reg.pready && !addr_ok;
		state_next.prdata = (access && !state_reg.pready && addr_ok) ? rd_value : 32'h0;

		if (wr_done) begin
			unique case (reg_idx)
				tick_pkg::RATE_CTRL_IDX: state_next.rate_ctrl = apb_i.pwdata[7:0];
				tick_pkg::SRC_CFG_IDX: begin
					state_next.pstop_en = apb_i.pwdata[tick_pkg::PSTOP_EN_BIT];
					state_next.pstop_sel = apb_i.pwdata[tick_pkg::PSTOP_SEL_BIT];
				end
				tick_pkg::EVT_MASK_IDX: state_next.evt_mask = apb_i.pwdata[tick_pkg::TICK_EVT_BIT];
				default: state_next.evt_mask = state_reg.evt_mask;
			endcase
		end

		// Counter: restart wins, off holds at zero, freeze keeps the count.
		if (restart || timer_off) begin
			state_next.pre_cnt = '0; // R3 R4 R6
			state_next.mod_cnt = '0;
		end else if (run_ok && src_edge) begin // R12
			if (state_reg.pre_cnt == prescale_len - tick_pkg::PRESCALE_CNT_W'(1)) begin
				state_next.pre_cnt = '0;
				if (period_end) begin
					state_next.mod_cnt = '0; // R13
				end else begin
					state_next.mod_cnt = state_reg.mod_cnt + tick_pkg::MODULUS_W'(1); // R7
				end
			end else begin
				state_next.pre_cnt = state_reg.pre_cnt + tick_pkg::PRESCALE_CNT_W'(1);
			end
		end

		// Sticky event flag; a read clears it but a same-cycle event wins.
		if (rd_done && reg_idx == tick_pkg::EVT_STATUS_IDX) begin
			state_next.evt_flag = 1'b0;
		end
		if (period_end && !restart) begin
			state_next.evt_flag = 1'b1; // R13
			state_next.tick = 1'b1;
		end
		state_next.irq = state_next.evt_flag && state_next.evt_mask;
	end

	// State register with synchronous reset to the documented zero values.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_reg <= '0; // R8
			state_reg.rate_ctrl <= tick_pkg::RATE_CTRL_RESET; // R8
			state_reg.src_sel <= tick_pkg::SRC_CFG_RESET[tick_pkg::SRC_SEL_BIT];
		end else begin
			state_reg <= state_next;
		end
	end

	assign pready_o = state_reg.pready;
	assign pslverr_o = state_reg.pslverr;
	assign prdata_o = state_reg.prdata;
	assign irq_o = state_reg.irq;
	assign tick_o = state_reg.tick;

endmodule

// File: bench/tick_timer_monitor.sv
`timescale 1ns/1ps
// Port checks of the tick timer; everything lives in the bus clock domain.
module tick_timer_monitor (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire tick_pkg::apb_req_t apb_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [31:0] prdata_o,
	input wire logic internal_rc_clock_i,
	input wire logic external_osc_clock_i,
	input wire logic oscillator_good_status_i,
	input wire logic stop_mode_i,
	input wire logic irq_o,
	input wire logic tick_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Bus timing, read data, error marking and quiet outputs after reset.
	property p_wait;
		apb_i.psel && apb_i.penable && !pready_o |=> pready_o ##1 !pready_o;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer timing wrong");
	property p_err;
		pready_o && apb_i.paddr == 12'h0fc |-> pslverr_o && prdata_o == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_idle;
		!pready_o |-> prdata_o == 32'h0 && !pslverr_o;
	endproperty
	a_idle: assert property (p_idle) else $error("bus outputs not idle");
	property p_reset;
		$fell(sys_rst_i) |-> !tick_o && !irq_o;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs busy after reset");
	// A tick needs a source edge, and a stopped oscillator-less stop freezes it.
	property p_quiet;
		($stable(internal_rc_clock_i) && $stable(external_osc_clock_i))[*8] |=> !tick_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("tick without source edges");
	property p_stop;
		(stop_mode_i && $stable(external_osc_clock_i))[*8] |=> !tick_o;
	endproperty
	a_stop: assert property (p_stop) else $error("tick during frozen stop");
	property p_pulse;
		tick_o |=> !tick_o [*8];
	endproperty
	a_pulse: assert property (p_pulse) else $error("tick pulse too long");
	property p_irq_rise;
		$rose(irq_o) |-> tick_o || $past(tick_o) || $past(pready_o) || $past(pready_o, 2);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
	property p_irq_fall;
		$fell(irq_o) |-> $past(pready_o) || $past(pready_o, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
	c_tick: cover property (tick_o);
	c_err: cover property (pready_o && pslverr_o);
	c_irq: cover property ($rose(irq_o));
endmodule

// File: bench/periodic_tick_timer_bench.sv
`timescale 1ns/1ps
module periodic_tick_timer_bench;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	tick_pkg::apb_req_t apb_i = '0;
	logic pready_o, pslverr_o, irq_o, tick_o, err;
	logic [31:0] prdata_o, rd;
	logic src = 1'b0, run = 1'b0, osc_on = 1'b0, good = 1'b0, stop = 1'b0, keep = 1'b0;
	logic [2:0] div = 3'h0;
	int edges = 0, num_errors = 0, checked = 0;
	periodic_tick_timer i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .apb_i(apb_i),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
		.internal_rc_clock_i(osc_on ? div[0] : src), .external_osc_clock_i(osc_on & src),
		.oscillator_good_status_i(good), .stop_mode_i(stop), .irq_o(irq_o), .tick_o(tick_o));
	always #12.5 mclk_i = ~mclk_i;
	// Slow source; stop changes far from source edges, and frozen edges are not counted.
	always @(posedge mclk_i) begin
		if (run) begin
			div <= div + 3'h1;
			if (div == 3'h3) stop <= ($urandom % 4 == 0);
			if (div == 3'h7) src <= ~src;
			if (div == 3'h7 && !src && !(stop && !keep)) edges <= edges + 1;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic end_sim();
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One transfer, held until ready; an idle cycle follows so strobes never double up.
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		apb_i.psel <= 1'b1;
		apb_i.pwrite <= wr;
		apb_i.paddr <= {2'h0, idx, 2'h0};
		apb_i.pwdata <= wd;
		@(posedge mclk_i);
		apb_i.penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 9);
		rd = prdata_o;
		err = pslverr_o;
		apb_i <= '0;
		@(posedge mclk_i);
		if (n >= 9) begin
			num_errors++;
			end_sim();
		end
	endtask
	// Expected period in source edges for a control byte.
	function automatic int exp_len(input logic [7:0] c);
		int dec[8] = '{1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};
		return (c[7] ? dec[c[6:4]] : 1 << (9 + c[6:4])) * (c[3:0] + 1);
	endfunction
	// Runs part of a period, rewrites the byte, then times one full period.
	task automatic measure(input logic [7:0] c);
		int n;
		apb(1'b1, tick_pkg::RATE_CTRL_IDX, {24'h0, c});
		for (int p = 0; p < 2; p++) begin
			edges <= 0;
			run <= 1'b1;
			n = 0;
			while ((p == 0 ? edges < 100 : tick_o !== 1'b1) && n < 40000) begin
				@(posedge mclk_i);
				n++;
			end
			run <= 1'b0;
			if (p == 0)
				apb(1'b1, tick_pkg::RATE_CTRL_IDX, {24'h0, c});
		end
		chk(32'(edges), 32'(exp_len(c)), "period");
		@(posedge mclk_i);
		stop <= 1'b0;
		if (n >= 40000) begin
			num_errors++;
			end_sim();
		end
	endtask
	initial begin
		void'($urandom(32'h6155));
		repeat (12) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		apb(1'b0, tick_pkg::RATE_CTRL_IDX, 32'h0);
		chk(rd, 32'h0, "control reset");
		apb(1'b0, 8'h3f, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped");
		apb(1'b1, tick_pkg::SRC_CFG_IDX, 32'h1);
		apb(1'b0, tick_pkg::SRC_CFG_IDX, 32'h0);
		chk(rd, 32'h0, "osc select while bad");
		apb(1'b1, tick_pkg::EVT_MASK_IDX, 32'h1);
		measure(8'h10);
		repeat (2) @(posedge mclk_i);
		chk({31'h0, irq_o}, 32'h1, "irq set");
		apb(1'b1, tick_pkg::EVT_MASK_IDX, 32'h0);
		@(posedge mclk_i);
		chk({31'h0, irq_o}, 32'h0, "irq masked");
		apb(1'b1, tick_pkg::EVT_MASK_IDX, 32'h1);
		apb(1'b0, tick_pkg::EVT_STATUS_IDX, 32'h0);
		chk(rd, 32'h1, "status set");
		apb(1'b0, tick_pkg::EVT_STATUS_IDX, 32'h0);
		chk(rd, 32'h0, "status cleared");
		chk({31'h0, irq_o}, 32'h0, "irq cleared");
		good <= 1'b1;
		apb(1'b1, tick_pkg::SRC_CFG_IDX, 32'h7);
		osc_on <= 1'b1;
		keep <= 1'b1;
		measure(8'h10 | 8'($urandom % 2));
		good <= 1'b0;
		repeat (3) @(posedge mclk_i);
		apb(1'b0, tick_pkg::SRC_CFG_IDX, 32'h0);
		chk(rd, 32'h6, "select lost");
		osc_on <= 1'b0;
		keep <= 1'b0;
		measure(8'h80);
		end_sim();
	end
endmodule
bind periodic_tick_timer tick_timer_monitor i_mon (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
	.apb_i(apb_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
	.internal_rc_clock_i(internal_rc_clock_i), .external_osc_clock_i(external_osc_clock_i),
	.oscillator_good_status_i(oscillator_good_status_i), .stop_mode_i(stop_mode_i),
	.irq_o(irq_o), .tick_o(tick_o));
